// ==== afe_regs_pkg.sv ====
// constants for the result and eeprom address register slice
package afe_regs_pkg;
    localparam logic [7:0] ADDR_AMP_HIGH = 8'h02;
    localparam logic [7:0] ADDR_AMP_LOW = 8'h03;
    localparam logic [7:0] ADDR_AUX_HIGH = 8'h04;
    localparam logic [7:0] ADDR_AUX_LOW = 8'h05;
    localparam logic [7:0] ADDR_TEMP_HIGH = 8'h06;
    localparam logic [7:0] ADDR_TEMP_LOW = 8'h07;
    localparam logic [7:0] ADDR_CHIP_ID = 8'h08;
    localparam logic [7:0] ADDR_EEP_HIGH = 8'h09;
    localparam logic [7:0] ADDR_EEP_LOW = 8'h0a;
    localparam logic [7:0] CHIP_ID_VALUE = 8'ha6; // arbitrary value
    localparam logic [15:0] SAT_POS = 16'h7fff;
    localparam logic [15:0] SAT_NEG = 16'h8000;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [9:0] TEMP_RESET = 10'h000;
    localparam logic [10:0] EEP_ADDR_RESET = 11'h000;
    localparam logic [1:0] SEL_TEMP = 2'h0;
    localparam logic [1:0] SEL_AMP = 2'h1;
    localparam logic [1:0] SEL_AUX = 2'h2;
    localparam int TEMP_LOW_SHIFT = 6;
    localparam int EEP_HIGH_BITS = 3;
endpackage

// ==== afe_result_and_eeprom_addr_regs.sv ====
// result, identification and eeprom address registers
`timescale 1ns/1ps
module afe_result_and_eeprom_addr_regs
    import afe_regs_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic soft_reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    input wire logic conv_done,
    input wire logic [1:0] measurement_select,
    input wire logic [16:0] conv_wide,
    input wire logic [9:0] conv_temp,
    output logic data_not_ready_flag,
    output logic gain_cal_overflow_flag,
    output logic [9:0] temperature_word,
    output logic [10:0] eeprom_address
);
    typedef struct packed {
        logic [15:0] amp;
        logic [15:0] aux;
        logic [9:0] temp;
        logic [10:0] eep;
        logic not_ready;
        logic ovf;
        logic [7:0] rdata;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic [15:0] sat_value;
    logic sat_ovf;
    logic [7:0] mux_data;
    logic mux_hit;
    logic result_read;

    result_saturate u_sat (
        .wide_value(conv_wide),
        .sat_value(sat_value),
        .overflow(sat_ovf)
    );

    read_mux u_mux (
        .addr(reg_addr),
        .amp_result(s_q.amp),
        .aux_result(s_q.aux),
        .temperature_value(s_q.temp),
        .eeprom_address(s_q.eep),
        .rdata(mux_data),
        .hit(mux_hit)
    );

    // reads of the amp/aux high byte or either temperature byte
    function automatic logic is_flag_read_addr(input logic [7:0] a);
        return a == ADDR_AMP_HIGH || a == ADDR_AUX_HIGH ||
            a == ADDR_TEMP_HIGH || a == ADDR_TEMP_LOW;
    endfunction

    assign result_read = reg_read && is_flag_read_addr(reg_addr);

    always_comb begin
        s_d = s_q;
        if (reg_read) begin
            s_d.rdata = mux_data;
        end
        if (result_read) begin
            s_d.not_ready = 1'b1;
            s_d.ovf = 1'b0;
        end
        if (reg_write) begin
            case (reg_addr)
                ADDR_TEMP_HIGH: s_d.temp[9:2] = reg_wdata;
                ADDR_TEMP_LOW:
                    s_d.temp[1:0] = reg_wdata[7:TEMP_LOW_SHIFT];
                ADDR_EEP_HIGH:
                    s_d.eep[10:8] = reg_wdata[EEP_HIGH_BITS-1:0];
                ADDR_EEP_LOW: s_d.eep[7:0] = reg_wdata;
                default: begin
                end
            endcase
        end
        // a new conversion wins over a concurrent read or write
        if (conv_done) begin
            case (measurement_select)
                SEL_TEMP: s_d.temp = conv_temp;
                SEL_AMP: s_d.amp = sat_value;
                SEL_AUX: s_d.aux = sat_value;
                default: begin
                end
            endcase
            if (measurement_select != 2'h3) begin
                s_d.not_ready = 1'b0;
                if ((measurement_select == SEL_AMP ||
                     measurement_select == SEL_AUX) && sat_ovf) begin
                    s_d.ovf = 1'b1;
                end
            end
        end
        if (soft_reset) begin
            s_d = '0;
            s_d.not_ready = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q.amp <= RESULT_RESET;
            s_q.aux <= RESULT_RESET;
            s_q.temp <= TEMP_RESET;
            s_q.eep <= EEP_ADDR_RESET;
            s_q.not_ready <= 1'b1;
            s_q.ovf <= 1'b0;
            s_q.rdata <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign reg_hit = mux_hit;
    assign data_not_ready_flag = s_q.not_ready;
    assign gain_cal_overflow_flag = s_q.ovf;
    assign temperature_word = s_q.temp;
    assign eeprom_address = s_q.eep;

    a_ready_clear: assert property (@(posedge clk)
        disable iff (!resetn)
        conv_done && measurement_select != 2'h3 && !soft_reset
        |=> !data_not_ready_flag)
        else $error("ready flag not cleared on new data");
    a_ready_set: assert property (@(posedge clk)
        disable iff (!resetn)
        result_read && !conv_done |=> data_not_ready_flag)
        else $error("ready flag not set on result read");
    a_flag_hold: assert property (@(posedge clk)
        disable iff (!resetn)
        !result_read && !conv_done && !soft_reset
        |=> data_not_ready_flag == $past(data_not_ready_flag))
        else $error("ready flag moved without cause");
    a_ovf_clear: assert property (@(posedge clk)
        disable iff (!resetn)
        reg_read && is_flag_read_addr(reg_addr) && !conv_done &&
        !soft_reset |=> !gain_cal_overflow_flag)
        else $error("overflow flag not cleared on result read");
    a_ovf_sticky: assert property (@(posedge clk)
        disable iff (!resetn)
        gain_cal_overflow_flag && !result_read && !soft_reset
        |=> gain_cal_overflow_flag)
        else $error("overflow flag dropped without a read");
    a_amp_sat: assert property (@(posedge clk)
        disable iff (!resetn)
        conv_done && measurement_select == SEL_AMP && !soft_reset &&
        conv_wide[16] && !conv_wide[15] |=> s_q.amp == SAT_NEG
        && gain_cal_overflow_flag)
        else $error("negative overflow not saturated");
    a_amp_pos: assert property (@(posedge clk)
        disable iff (!resetn)
        conv_done && measurement_select == SEL_AMP && !soft_reset &&
        !conv_wide[16] && conv_wide[15] |=> s_q.amp == SAT_POS
        && gain_cal_overflow_flag)
        else $error("amp positive overflow not saturated");
    a_aux_pos: assert property (@(posedge clk)
        disable iff (!resetn)
        conv_done && measurement_select == SEL_AUX && !soft_reset &&
        !conv_wide[16] && conv_wide[15] |=> s_q.aux == SAT_POS
        && gain_cal_overflow_flag)
        else $error("positive overflow not saturated");
    a_aux_neg: assert property (@(posedge clk)
        disable iff (!resetn)
        conv_done && measurement_select == SEL_AUX && !soft_reset &&
        conv_wide[16] && !conv_wide[15] |=> s_q.aux == SAT_NEG
        && gain_cal_overflow_flag)
        else $error("aux negative overflow not saturated");
    a_amp_load: assert property (@(posedge clk)
        disable iff (!resetn)
        conv_done && measurement_select == SEL_AMP && !soft_reset &&
        conv_wide[16] == conv_wide[15] |=> s_q.amp == $past(conv_wide[15:0]))
        else $error("amp result not loaded");
    a_aux_load: assert property (@(posedge clk)
        disable iff (!resetn)
        conv_done && measurement_select == SEL_AUX && !soft_reset &&
        conv_wide[16] == conv_wide[15] |=> s_q.aux == $past(conv_wide[15:0]))
        else $error("aux result not loaded");
    a_temp_load: assert property (@(posedge clk)
        disable iff (!resetn)
        conv_done && measurement_select == SEL_TEMP && !soft_reset
        |=> temperature_word == $past(conv_temp))
        else $error("temperature result not loaded");
    a_reserved_sel: assert property (@(posedge clk)
        disable iff (!resetn)
        conv_done && measurement_select == 2'h3 && !reg_write &&
        !reg_read && !soft_reset |=> temperature_word ==
        $past(temperature_word) && data_not_ready_flag ==
        $past(data_not_ready_flag))
        else $error("reserved select changed state");
    a_amp_hold: assert property (@(posedge clk)
        disable iff (!resetn)
        !conv_done && !soft_reset |=> s_q.amp == $past(s_q.amp))
        else $error("amp result changed without conversion");
    a_aux_hold: assert property (@(posedge clk)
        disable iff (!resetn)
        !conv_done && !soft_reset |=> s_q.aux == $past(s_q.aux))
        else $error("aux result changed without conversion");
    a_temp_write: assert property (@(posedge clk)
        disable iff (!resetn)
        reg_write && reg_addr == ADDR_TEMP_HIGH && !conv_done &&
        !soft_reset |=> temperature_word[9:2] == $past(reg_wdata))
        else $error("temperature write lost");
    a_temp_low_write: assert property (@(posedge clk)
        disable iff (!resetn)
        reg_write && reg_addr == ADDR_TEMP_LOW && !conv_done &&
        !soft_reset |=> temperature_word[1:0] == $past(reg_wdata[7:6]))
        else $error("temperature fraction write lost");
    a_eep_write: assert property (@(posedge clk)
        disable iff (!resetn)
        reg_write && reg_addr == ADDR_EEP_HIGH && !soft_reset
        |=> eeprom_address[10:8] == $past(reg_wdata[2:0]))
        else $error("eeprom high address write lost");
    a_eep_low_write: assert property (@(posedge clk)
        disable iff (!resetn)
        reg_write && reg_addr == ADDR_EEP_LOW && !soft_reset
        |=> eeprom_address[7:0] == $past(reg_wdata))
        else $error("eeprom low address write lost");
    a_eep_hold: assert property (@(posedge clk)
        disable iff (!resetn)
        !reg_write && !soft_reset
        |=> eeprom_address == $past(eeprom_address))
        else $error("eeprom address changed without write");
    a_soft_flags: assert property (@(posedge clk)
        disable iff (!resetn)
        soft_reset |=> data_not_ready_flag && !gain_cal_overflow_flag)
        else $error("flags wrong after software reset");
    a_soft_regs: assert property (@(posedge clk)
        disable iff (!resetn)
        soft_reset |=> eeprom_address == EEP_ADDR_RESET &&
        temperature_word == TEMP_RESET)
        else $error("registers not cleared by software reset");
    a_id_read: assert property (@(posedge clk)
        disable iff (!resetn)
        reg_read && reg_addr == ADDR_CHIP_ID && !soft_reset
        |=> reg_rdata == CHIP_ID_VALUE)
        else $error("identification value wrong");
    a_amp_order: assert property (@(posedge clk)
        disable iff (!resetn)
        reg_read && reg_addr == ADDR_AMP_HIGH && !soft_reset
        |=> reg_rdata == $past(s_q.amp[15:8]))
        else $error("amp high byte wrong");
    a_amp_low_read: assert property (@(posedge clk)
        disable iff (!resetn)
        reg_read && reg_addr == ADDR_AMP_LOW && !soft_reset
        |=> reg_rdata == $past(s_q.amp[7:0]))
        else $error("amp low byte wrong");
    a_aux_order: assert property (@(posedge clk)
        disable iff (!resetn)
        reg_read && reg_addr == ADDR_AUX_HIGH && !soft_reset
        |=> reg_rdata == $past(s_q.aux[15:8]))
        else $error("aux high byte wrong");
    a_aux_low_read: assert property (@(posedge clk)
        disable iff (!resetn)
        reg_read && reg_addr == ADDR_AUX_LOW && !soft_reset
        |=> reg_rdata == $past(s_q.aux[7:0]))
        else $error("aux low byte wrong");
    a_temp_high_read: assert property (@(posedge clk)
        disable iff (!resetn)
        reg_read && reg_addr == ADDR_TEMP_HIGH && !soft_reset
        |=> reg_rdata == $past(temperature_word[9:2]))
        else $error("temperature high byte wrong");
    a_temp_low_zero: assert property (@(posedge clk)
        disable iff (!resetn)
        reg_read && reg_addr == ADDR_TEMP_LOW && !soft_reset
        |=> reg_rdata[5:0] == 6'h00)
        else $error("unused temperature bits not zero");
    a_eep_zero: assert property (@(posedge clk)
        disable iff (!resetn)
        reg_read && reg_addr == ADDR_EEP_HIGH && !soft_reset
        |=> reg_rdata[7:3] == 5'h00)
        else $error("unused eeprom bits not zero");
    a_eep_low_read: assert property (@(posedge clk)
        disable iff (!resetn)
        reg_read && reg_addr == ADDR_EEP_LOW && !soft_reset
        |=> reg_rdata == $past(eeprom_address[7:0]))
        else $error("eeprom low address read wrong");
    a_unmapped_read: assert property (@(posedge clk)
        disable iff (!resetn)
        reg_read && !reg_hit && !soft_reset
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // afe_result_and_eeprom_addr_regs

// ==== host_model.sv ====
// host side model issuing register byte reads and writes
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    // write data is inverted on release so stale data is never seen
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        reg_wdata <= ~d;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule // host_model

// ==== read_mux.sv ====
// register read data selection
`timescale 1ns/1ps
module read_mux
    import afe_regs_pkg::*;
(
    input wire logic [7:0] addr,
    input wire logic [15:0] amp_result,
    input wire logic [15:0] aux_result,
    input wire logic [9:0] temperature_value,
    input wire logic [10:0] eeprom_address,
    output logic [7:0] rdata,
    output logic hit
);
    always_comb begin
        hit = 1'b1;
        case (addr)
            ADDR_AMP_HIGH: rdata = amp_result[15:8];
            ADDR_AMP_LOW: rdata = amp_result[7:0];
            ADDR_AUX_HIGH: rdata = aux_result[15:8];
            ADDR_AUX_LOW: rdata = aux_result[7:0];
            ADDR_TEMP_HIGH: rdata = temperature_value[9:2];
            ADDR_TEMP_LOW: rdata = {temperature_value[1:0], 6'h00};
            ADDR_CHIP_ID: rdata = CHIP_ID_VALUE;
            ADDR_EEP_HIGH: rdata = {5'h00, eeprom_address[10:8]};
            ADDR_EEP_LOW: rdata = eeprom_address[7:0];
            default: begin
                rdata = 8'h00;
                hit = 1'b0;
            end
        endcase
    end
endmodule // read_mux

// ==== result_saturate.sv ====
// gain-calibrated result saturation to signed 16 bits
`timescale 1ns/1ps
module result_saturate
    import afe_regs_pkg::*;
(
    input wire logic [16:0] wide_value,
    output logic [15:0] sat_value,
    output logic overflow
);
    always_comb begin
        overflow = wide_value[16] != wide_value[15];
        if (!overflow) begin
            sat_value = wide_value[15:0];
        end else if (wide_value[16]) begin
            sat_value = SAT_NEG;
        end else begin
            sat_value = SAT_POS;
        end
    end
endmodule // result_saturate

// ==== tb_afe_result_and_eeprom_addr_regs.sv ====
// self-checking bench for the result and eeprom address registers
`timescale 1ns/1ps
module tb_afe_result_and_eeprom_addr_regs;
    import afe_regs_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic soft_reset = 1'b0;
    logic conv_done = 1'b0;
    logic [1:0] measurement_select = 2'h0;
    logic [16:0] conv_wide = 17'h00000;
    logic [9:0] conv_temp = 10'h000;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic reg_write, reg_read, reg_hit, nrdy, ovf;
    logic [9:0] temperature_word;
    logic [10:0] eeprom_address;
    int n_errors = 0;
    int num_checks = 0;
    always #20 clk = ~clk;
    host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
    afe_result_and_eeprom_addr_regs dut (.clk(clk), .resetn(resetn),
        .soft_reset(soft_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .conv_done(conv_done),
        .measurement_select(measurement_select), .conv_wide(conv_wide),
        .conv_temp(conv_temp), .data_not_ready_flag(nrdy),
        .gain_cal_overflow_flag(ovf), .temperature_word(temperature_word),
        .eeprom_address(eeprom_address));
    task automatic results();
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, v);
        chk({8'h00, v}, {8'h00, exp});
    endtask
    task automatic conv(input logic [1:0] s, input logic [16:0] w,
                        input logic [9:0] t);
        @(posedge clk);
        measurement_select <= s;
        conv_wide <= w;
        conv_temp <= t;
        conv_done <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
        #1;
    endtask
    initial begin
        #100000;
        n_errors++;
        results();
    end
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        chk(16'(nrdy), 16'h0001);
        chk(16'(eeprom_address), 16'h0000);
        host.wr(ADDR_CHIP_ID, 8'h00);
        rchk(ADDR_CHIP_ID, CHIP_ID_VALUE);
        chk(16'(reg_hit), 16'h0001);
        conv(SEL_AMP, 17'h01234, 10'h000);
        chk(16'(nrdy), 16'h0000);
        host.wr(ADDR_AMP_HIGH, 8'hff);
        rchk(ADDR_AMP_HIGH, 8'h12);
        chk(16'(nrdy), 16'h0001);
        rchk(ADDR_AMP_LOW, 8'h34);
        conv(SEL_AMP, 17'h0ffff, 10'h000);
        chk(16'(ovf), 16'h0001);
        rchk(ADDR_AMP_HIGH, 8'h7f);
        chk(16'(ovf), 16'h0000);
        rchk(ADDR_AMP_LOW, 8'hff);
        conv(SEL_AUX, 17'h1fedc, 10'h000);
        rchk(ADDR_AUX_HIGH, 8'hfe);
        rchk(ADDR_AUX_LOW, 8'hdc);
        conv(SEL_AUX, 17'h10000, 10'h000);
        rchk(ADDR_AUX_HIGH, 8'h80);
        conv(SEL_TEMP, 17'h00000, 10'h2d7);
        chk(16'(temperature_word), 16'h02d7);
        rchk(ADDR_TEMP_HIGH, 8'hb5);
        rchk(ADDR_TEMP_LOW, 8'hc0);
        conv(2'h3, 17'h00001, 10'h001);
        chk(16'(temperature_word), 16'h02d7);
        rchk(ADDR_AMP_HIGH, 8'h7f);
        conv(SEL_AMP, 17'h10000, 10'h000);
        chk(16'(ovf), 16'h0001);
        rchk(ADDR_AMP_HIGH, 8'h80);
        rchk(ADDR_AMP_LOW, 8'h00);
        conv(SEL_AUX, 17'h08000, 10'h000);
        rchk(ADDR_AUX_HIGH, 8'h7f);
        rchk(ADDR_AUX_LOW, 8'hff);
        host.wr(ADDR_TEMP_HIGH, 8'h3c);
        host.wr(ADDR_TEMP_LOW, 8'h7f);
        chk(16'(temperature_word), 16'h00f1);
        rchk(ADDR_TEMP_LOW, 8'h40);
        host.wr(ADDR_EEP_HIGH, 8'he5);
        host.wr(ADDR_EEP_LOW, 8'h5a);
        chk(16'(eeprom_address), 16'h055a);
        rchk(ADDR_EEP_HIGH, 8'h05);
        rchk(ADDR_EEP_LOW, 8'h5a);
        rchk(8'h20, 8'h00);
        chk(16'(reg_hit), 16'h0000);
        conv(SEL_AMP, 17'h04200, 10'h000);
        @(posedge clk);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        #1;
        chk(16'(eeprom_address), 16'h0000);
        chk(16'(temperature_word), 16'h0000);
        chk(16'(nrdy), 16'h0001);
        rchk(ADDR_AMP_HIGH, 8'h00);
        host.wr(ADDR_EEP_LOW, 8'h33);
        chk(16'(eeprom_address), 16'h0033);
        conv(SEL_TEMP, 17'h00000, 10'h155);
        chk(16'(nrdy), 16'h0000);
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        chk(16'(eeprom_address), 16'h0000);
        chk(16'(temperature_word), 16'h0000);
        chk(16'(nrdy), 16'h0001);
        results();
    end
endmodule // tb_afe_result_and_eeprom_addr_regs
